//--- auth_lockout.sv
// Authentication gate with persistent consecutive-failure lockout.
// Assumes secrets and counters come from protected storage, and that the
// persistent store acknowledges each counter write once it is durable.
`timescale 1ns/1ps
// Function
// - Cap consecutive failures per role at fifteen
// - Failure count kept in power-safe storage
// - Reaching limit erases keys and media
// - Wrapped key is two full 256-bit halves
// - Combined mode: password first, then key
// - User password up to 64 bytes accepted
// - Officer password is 32-byte field
// - No data reads or writes before unlock
// - Locked device answers informational commands only
module auth_lockout #(
	parameter int LIMIT = auth_pkg::PENALTY_LIMIT
) (
	input logic MCLK,
	input logic NRST,
	input logic PENALTY_EN,
	input auth_pkg::mode_t MODE,
	input logic CRED_VALID,
	output logic CRED_READY,
	input auth_pkg::role_t CRED_ROLE,
	input auth_pkg::kind_t CRED_KIND,
	input logic [auth_pkg::USER_PW_BITS-1:0] CRED_PW,
	input logic [auth_pkg::PW_LEN_W-1:0] CRED_PW_LEN,
	input logic [auth_pkg::KEY_HALF_BITS-1:0] CRED_CIPHER,
	input logic [auth_pkg::KEY_HALF_BITS-1:0] CRED_TWEAK,
	input logic [auth_pkg::USER_PW_BITS-1:0] REF_USER_PW,
	input logic [auth_pkg::PW_LEN_W-1:0] REF_USER_PW_LEN,
	input logic [auth_pkg::CFG_PW_BITS-1:0] REF_CFG_PW,
	input logic [auth_pkg::KEY_HALF_BITS-1:0] REF_CIPHER,
	input logic [auth_pkg::KEY_HALF_BITS-1:0] REF_TWEAK,
	output logic AUTH_DONE,
	output logic AUTH_PASS,
	output logic AUTH_REFUSED,
	output logic USER_UNLOCKED,
	output logic OFFICER_UNLOCKED,
	output logic PW_STAGE_OK,
	input logic [auth_pkg::CNT_W-1:0] NV_USER_CNT,
	input logic [auth_pkg::CNT_W-1:0] NV_OFF_CNT,
	output logic NV_WR_EN,
	input logic NV_WR_ACK,
	output logic [auth_pkg::CNT_W-1:0] NV_WR_USER_CNT,
	output logic [auth_pkg::CNT_W-1:0] NV_WR_OFF_CNT,
	output logic ERASE_REQ,
	input logic ERASE_DONE,
	input logic CMD_VALID,
	input auth_pkg::cmd_class_t CMD_CLASS,
	output logic CMD_ALLOW
);
	import auth_pkg::*;

	// Limit at counter width
	localparam logic [CNT_W-1:0] LIM = CNT_W'(LIMIT);

	// Controller state
	state_t state_r, state_nxt;
	// Failure counters, mirrors of persistent copies
	logic [CNT_W-1:0] user_cnt_r, user_cnt_nxt;
	logic [CNT_W-1:0] off_cnt_r, off_cnt_nxt;
	// Unlock levels per role
	logic user_unl_r, user_unl_nxt;
	logic off_unl_r, off_unl_nxt;
	// Correct password seen in combined mode
	logic stage_r, stage_nxt;
	// Wipe owed after the current counter write
	logic erase_pend_r, erase_pend_nxt;
	// Result owed when the counter write lands
	logic done_pend_r, done_pend_nxt;
	// Result pulse and flags
	logic done_r, done_nxt;
	logic pass_r, pass_nxt;
	logic refused_r, refused_nxt;
	// Captured presentation
	role_t role_r, role_nxt;
	kind_t kind_r, kind_nxt;
	logic [USER_PW_BITS-1:0] pw_r, pw_nxt;
	logic [PW_LEN_W-1:0] pw_len_r, pw_len_nxt;
	logic [KEY_HALF_BITS-1:0] cipher_r, cipher_nxt;
	logic [KEY_HALF_BITS-1:0] tweak_r, tweak_nxt;
	// Presentation accepted this cycle
	logic take;
	// Presentation refused outright, never checked
	logic reject;
	// Check verdict and its next failure count
	logic ok;
	logic [CNT_W-1:0] fail_cnt;

	// Link to the comparator
	cred_if cif ();

	cred_compare u_cmp (
		.cif(cif)
	);

	// Feed registered presentation values and the reference inputs so verdicts are stable in S_CHECK
	assign cif.pw = pw_r;
	assign cif.pw_len = pw_len_r;
	assign cif.cipher = cipher_r;
	assign cif.tweak = tweak_r;
	assign cif.ref_pw = REF_USER_PW;
	assign cif.ref_pw_len = REF_USER_PW_LEN;
	assign cif.ref_cfg = REF_CFG_PW;
	assign cif.ref_cipher = REF_CIPHER;
	assign cif.ref_tweak = REF_TWEAK;

	// Only idle takes new credentials; busy back-pressures the host
	assign CRED_READY = (state_r == S_IDLE);
	assign take = CRED_VALID && CRED_READY;

	// Kind that does not fit the mode is refused, not counted
	always_comb
	begin
		reject = 1'b0;
		if (CRED_ROLE == ROLE_USER)
		begin
			unique case (MODE)
				MODE_PW: reject = (CRED_KIND == KIND_KEY);
				MODE_KEY: reject = (CRED_KIND == KIND_PW);
				MODE_PW_KEY: reject = (CRED_KIND == KIND_KEY) && !stage_r;
				default: reject = 1'b1;
			endcase
		end
	end

	// Verdict of the captured presentation
	always_comb
	begin
		if (role_r == ROLE_OFFICER)
			ok = cif.cfg_match;
		else if (kind_r == KIND_PW)
			ok = cif.pw_match;
		else
			ok = cif.key_match;
	end

	assign fail_cnt = ((role_r == ROLE_USER) ? user_cnt_r : off_cnt_r) >= LIM ?
		LIM : ((role_r == ROLE_USER) ? user_cnt_r : off_cnt_r) + CNT_W'(1);

	// Capture group next values
	always_comb
	begin
		role_nxt = role_r;
		kind_nxt = kind_r;
		pw_nxt = pw_r;
		pw_len_nxt = pw_len_r;
		cipher_nxt = cipher_r;
		tweak_nxt = tweak_r;
		if (take)
		begin
			role_nxt = CRED_ROLE;
			kind_nxt = CRED_KIND;
			pw_nxt = CRED_PW;
			pw_len_nxt = CRED_PW_LEN;
			cipher_nxt = CRED_CIPHER;
			tweak_nxt = CRED_TWEAK;
		end
	end

	// Capture group registers
	always_ff @(posedge MCLK)
	begin
		if (!NRST)
		begin
			role_r <= ROLE_USER;
			kind_r <= KIND_PW;
			pw_r <= '0;
			pw_len_r <= '0;
			cipher_r <= '0;
			tweak_r <= '0;
		end
		else
		begin
			role_r <= role_nxt;
			kind_r <= kind_nxt;
			pw_r <= pw_nxt;
			pw_len_r <= pw_len_nxt;
			cipher_r <= cipher_nxt;
			tweak_r <= tweak_nxt;
		end
	end

	// Controller next values
	always_comb
	begin
		state_nxt = state_r;
		user_cnt_nxt = user_cnt_r;
		off_cnt_nxt = off_cnt_r;
		user_unl_nxt = user_unl_r;
		off_unl_nxt = off_unl_r;
		stage_nxt = stage_r;
		erase_pend_nxt = erase_pend_r;
		done_pend_nxt = done_pend_r;
		done_nxt = 1'b0;
		pass_nxt = pass_r;
		refused_nxt = refused_r;
		unique case (state_r)
			S_LOAD:
			begin
				// counts come back from the persistent copy
				user_cnt_nxt = NV_USER_CNT;
				off_cnt_nxt = NV_OFF_CNT;
				// wipe cut short by power loss is resumed
				if (PENALTY_EN && (NV_USER_CNT >= LIM || NV_OFF_CNT >= LIM))
				begin
					erase_pend_nxt = 1'b1;
					state_nxt = S_ERASE;
				end
				else
					state_nxt = S_IDLE;
			end
			S_IDLE:
			begin
				if (take && reject)
				begin
					// Answer at once, counter untouched
					done_nxt = 1'b1;
					pass_nxt = 1'b0;
					refused_nxt = 1'b1;
				end
				else if (take)
					state_nxt = S_CHECK;
			end
			S_CHECK:
			begin
				pass_nxt = ok;
				refused_nxt = 1'b0;
				done_pend_nxt = 1'b1;
				state_nxt = S_NVWR;
				if (ok && role_r == ROLE_OFFICER)
				begin
					off_cnt_nxt = CNT_RESET;
					off_unl_nxt = 1'b1;
				end
				else if (ok && kind_r == KIND_PW && MODE == MODE_PW_KEY)
					// first factor only; count kept so key guesses still add up
					stage_nxt = 1'b1;
				else if (ok)
				begin
					user_cnt_nxt = CNT_RESET;
					user_unl_nxt = 1'b1;
					stage_nxt = 1'b0;
				end
				else
				begin
					// every failed check counts, wrong key included
					if (role_r == ROLE_USER)
					begin
						user_cnt_nxt = fail_cnt;
						stage_nxt = 1'b0;
					end
					else
						off_cnt_nxt = fail_cnt;
					if (PENALTY_EN && fail_cnt >= LIM)
					begin
						erase_pend_nxt = 1'b1;
						user_unl_nxt = 1'b0;
						off_unl_nxt = 1'b0;
						stage_nxt = 1'b0;
					end
				end
			end
			S_NVWR:
			begin
				// answer only once the count is durable
				if (NV_WR_ACK)
				begin
					done_nxt = done_pend_r;
					done_pend_nxt = 1'b0;
					state_nxt = erase_pend_r ? S_ERASE : S_IDLE;
				end
			end
			S_ERASE:
			begin
				// keys and media gone, start afresh locked
				if (ERASE_DONE)
				begin
					user_cnt_nxt = CNT_RESET;
					off_cnt_nxt = CNT_RESET;
					user_unl_nxt = 1'b0;
					off_unl_nxt = 1'b0;
					stage_nxt = 1'b0;
					erase_pend_nxt = 1'b0;
					state_nxt = S_NVWR;
				end
			end
			// Illegal code recovers through a fresh load
			default: state_nxt = S_LOAD;
		endcase
	end

	// Controller registers
	always_ff @(posedge MCLK)
	begin
		if (!NRST)
		begin
			state_r <= S_LOAD;
			user_cnt_r <= CNT_RESET;
			off_cnt_r <= CNT_RESET;
			user_unl_r <= 1'b0;
			off_unl_r <= 1'b0;
			stage_r <= 1'b0;
			erase_pend_r <= 1'b0;
			done_pend_r <= 1'b0;
			done_r <= 1'b0;
			pass_r <= 1'b0;
			refused_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			user_cnt_r <= user_cnt_nxt;
			off_cnt_r <= off_cnt_nxt;
			user_unl_r <= user_unl_nxt;
			off_unl_r <= off_unl_nxt;
			stage_r <= stage_nxt;
			erase_pend_r <= erase_pend_nxt;
			done_pend_r <= done_pend_nxt;
			done_r <= done_nxt;
			pass_r <= pass_nxt;
			refused_r <= refused_nxt;
		end
	end

	// Command gate
	always_comb
	begin
		CMD_ALLOW = 1'b0;
		if (CMD_VALID)
		begin
			unique case (CMD_CLASS)
				CMD_INFO: CMD_ALLOW = 1'b1;
				CMD_READ: CMD_ALLOW = user_unl_r;
				CMD_WRITE: CMD_ALLOW = user_unl_r;
				CMD_CONFIG: CMD_ALLOW = off_unl_r;
			endcase
		end
	end

	// Registered results and levels
	assign AUTH_DONE = done_r;
	assign AUTH_PASS = pass_r;
	assign AUTH_REFUSED = refused_r;
	assign USER_UNLOCKED = user_unl_r;
	assign OFFICER_UNLOCKED = off_unl_r;
	assign PW_STAGE_OK = stage_r;
	assign NV_WR_USER_CNT = user_cnt_r;
	assign NV_WR_OFF_CNT = off_cnt_r;
	// Handshake strobes
	assign NV_WR_EN = (state_r == S_NVWR);
	assign ERASE_REQ = (state_r == S_ERASE);

endmodule : auth_lockout

//--- auth_lockout_sva.sv
// Checker for the lockout gate, watching top-level ports only.
// Assumes the store answers writes and erases within a few dozen cycles.
`timescale 1ns/1ps
module auth_lockout_sva
	import auth_pkg::*;
#(
	parameter int LIMIT = PENALTY_LIMIT
) (
	input logic MCLK,
	input logic NRST,
	input logic PENALTY_EN,
	input logic USER_UNLOCKED,
	input logic OFFICER_UNLOCKED,
	input logic NV_WR_EN,
	input logic NV_WR_ACK,
	input logic [CNT_W-1:0] NV_WR_USER_CNT,
	input logic ERASE_REQ,
	input logic ERASE_DONE,
	input logic CMD_VALID,
	input cmd_class_t CMD_CLASS,
	input logic CMD_ALLOW
);
	// One clock domain, so one clocking and one reset guard
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!NRST);

	a_info_open: assert property (CMD_VALID && CMD_CLASS == CMD_INFO |-> CMD_ALLOW)
		else $error("info command blocked");
	a_data_gated: assert property (CMD_VALID && CMD_CLASS inside {CMD_READ, CMD_WRITE}
		|-> CMD_ALLOW == USER_UNLOCKED) else $error("data command gate wrong");
	a_config_gated: assert property (CMD_VALID && CMD_CLASS == CMD_CONFIG
		|-> CMD_ALLOW == OFFICER_UNLOCKED) else $error("config command gate wrong");
	a_unlock_clears: assert property ($rose(USER_UNLOCKED)
		|-> NV_WR_EN && NV_WR_USER_CNT == CNT_RESET) else $error("unlock kept count");
	a_count_cap: assert property (NV_WR_EN |-> NV_WR_USER_CNT <= LIMIT)
		else $error("count above limit");
	a_nv_hold: assert property (NV_WR_EN && !NV_WR_ACK
		|=> NV_WR_EN && $stable(NV_WR_USER_CNT)) else $error("count write dropped");
	// Write of the limit value must lead to a wipe within 60 cycles of the write starting
	a_limit_wipes: assert property ($rose(NV_WR_EN) && PENALTY_EN && NV_WR_USER_CNT == LIMIT
		|-> ##[1:60] ERASE_REQ) else $error("limit reached without wipe");
	a_wipe_locks: assert property (ERASE_REQ |-> !USER_UNLOCKED && !OFFICER_UNLOCKED)
		else $error("unlocked during wipe");
	a_erase_holds: assert property (ERASE_REQ && !ERASE_DONE |=> ERASE_REQ)
		else $error("erase request dropped early");

	// Main scenarios reached
	c_unlock: cover property ($rose(USER_UNLOCKED));
	c_wipe: cover property ($rose(ERASE_REQ));
	c_config: cover property (CMD_VALID && CMD_CLASS == CMD_CONFIG && CMD_ALLOW);
endmodule : auth_lockout_sva

bind auth_lockout auth_lockout_sva #(.LIMIT(LIMIT)) auth_lockout_sva_inst (.*);

//--- auth_lockout_test.sv
// Self-checking bench for the lockout gate with a store model beside it.
// Assumes the hand-over timing; results are checked as they appear.
`timescale 1ns/1ps
module auth_lockout_test;
	import auth_pkg::*;
	logic MCLK = 0, NRST = 0, PENALTY_EN = 0, CRED_VALID = 0, CMD_VALID = 0, slow = 0;
	mode_t MODE = MODE_PW;
	role_t CRED_ROLE = ROLE_USER;
	kind_t CRED_KIND = KIND_PW;
	cmd_class_t CMD_CLASS = CMD_INFO;
	logic [USER_PW_BITS-1:0] CRED_PW = '0, REF_USER_PW;
	logic [PW_LEN_W-1:0] CRED_PW_LEN = '0, REF_USER_PW_LEN;
	logic [KEY_HALF_BITS-1:0] CRED_CIPHER = '0, CRED_TWEAK = '0, REF_CIPHER, REF_TWEAK;
	logic [CFG_PW_BITS-1:0] REF_CFG_PW;
	logic [CNT_W-1:0] NV_USER_CNT, NV_OFF_CNT, NV_WR_USER_CNT, NV_WR_OFF_CNT;
	logic CRED_READY, AUTH_DONE, AUTH_PASS, AUTH_REFUSED, USER_UNLOCKED, OFFICER_UNLOCKED;
	logic PW_STAGE_OK, NV_WR_EN, NV_WR_ACK, ERASE_REQ, ERASE_DONE, CMD_ALLOW;
	int seed = 1, mismatches = 0, n_checks = 0, ndone = 0, cycles = 0;
	logic [1:0] q[$]; // Expected {pass, refused} per presentation
	logic [511:0] upw, cpw, key, bad, badc;
	logic erase_seen = 0; // Wipe observed since last clear

	always #20 MCLK = ~MCLK;

	auth_lockout #(.LIMIT(PENALTY_LIMIT)) auth_lockout_inst (.*);
	nv_store_model nv_store_model_inst (.clk(MCLK), .slow(slow), .wr_en(NV_WR_EN),
		.wr_user(NV_WR_USER_CNT), .wr_off(NV_WR_OFF_CNT), .erase_req(ERASE_REQ),
		.user_cnt(NV_USER_CNT), .off_cnt(NV_OFF_CNT), .wr_ack(NV_WR_ACK), .erase_done(ERASE_DONE));

	task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	// Printable non-space bytes, the host's side of the password rules
	function automatic logic [511:0] mkpw(int n);
		logic [511:0] v;
		v = '0;
		for (int i = 0; i < n; i++) v[8*i +: 8] = 8'h21 + 8'($unsigned($random(seed)) % 94);
		return v;
	endfunction : mkpw

	function automatic logic [511:0] mkkey();
		logic [511:0] v;
		for (int i = 0; i < 16; i++) v[32*i +: 32] = $random(seed);
		return v;
	endfunction : mkkey

	task automatic rst(mode_t m, logic p);
		@(negedge MCLK);
		NRST = 0;
		MODE = m;
		PENALTY_EN = p;
		repeat (8) @(negedge MCLK);
		NRST = 1;
	endtask : rst

	task automatic waitrdy();
		int t;
		t = 0;
		do @(negedge MCLK); while (CRED_READY !== 1'b1 && ++t < 300);
	endtask : waitrdy

	// One whole credential, held until taken, then wait for its result
	task automatic pres(role_t r, kind_t k, logic [511:0] p, int l, logic [511:0] kv,
		logic [1:0] e);
		int t, n0;
		waitrdy();
		CRED_ROLE = r;
		CRED_KIND = k;
		CRED_PW = p;
		CRED_PW_LEN = 7'(l);
		CRED_CIPHER = kv[255:0];
		CRED_TWEAK = kv[511:256];
		CRED_VALID = 1;
		q.push_back(e);
		n0 = ndone;
		t = 0;
		@(negedge MCLK);
		CRED_VALID = 0;
		chk("busy", CRED_READY, e == 2'b01);
		while (ndone == n0 && ++t < 300) @(negedge MCLK);
	endtask : pres

	// Every command class against the expected unlock state
	task automatic cmds(logic u, logic o);
		for (int c = 0; c < 4; c++)
		begin
			@(negedge MCLK);
			CMD_VALID = 1;
			CMD_CLASS = cmd_class_t'(c);
			#1 chk("allow", CMD_ALLOW, c == 0 || (c < 3 ? u : o));
		end
		CMD_VALID = 0;
	endtask : cmds

	// Result watcher, oldest note first
	always @(negedge MCLK)
	begin
		if (ERASE_REQ === 1'b1)
			erase_seen = 1;
		if (NRST && AUTH_DONE === 1'b1)
		begin
			ndone++;
			chk("result", {AUTH_PASS, AUTH_REFUSED}, q.size() ? q.pop_front() : 2'bxx);
		end
	end

	// Hang guard, far above the few hundred cycles expected
	always @(posedge MCLK)
		if (++cycles == 20000)
		begin
			mismatches++;
			close_out();
		end

	initial
	begin
		upw = mkpw(64);
		cpw = mkpw(32);
		key = mkkey();
		{REF_USER_PW, REF_USER_PW_LEN, REF_CFG_PW} = {upw, 7'h40, cpw[255:0]};
		{REF_TWEAK, REF_CIPHER} = key;
		bad = upw;
		bad[511:504] = (bad[511:504] == 8'h21) ? 8'h22 : 8'h21;
		badc = cpw;
		badc[255:248] = (badc[255:248] == 8'h21) ? 8'h22 : 8'h21;
		// Password mode: last byte, short and over-long lengths all fail
		rst(MODE_PW, 1'b1);
		cmds(0, 0);
		pres(ROLE_USER, KIND_PW, bad, 64, key, 2'b00);
		pres(ROLE_USER, KIND_PW, upw, 65, key, 2'b00);
		pres(ROLE_USER, KIND_PW, upw, 63, key, 2'b00);
		chk("user count", NV_USER_CNT, 8'h03);
		pres(ROLE_USER, KIND_KEY, upw, 64, key, 2'b01);
		chk("refused uncounted", NV_USER_CNT, 8'h03);
		pres(ROLE_USER, KIND_PW, upw, 64, key, 2'b10);
		chk("user cleared", NV_USER_CNT, 8'h00);
		cmds(1, 0);
		// Officer field compared to its last byte
		pres(ROLE_OFFICER, KIND_PW, badc, 32, key, 2'b00);
		chk("officer count", NV_OFF_CNT, 8'h01);
		pres(ROLE_OFFICER, KIND_PW, cpw, 32, key, 2'b10);
		chk("officer cleared", {OFFICER_UNLOCKED, NV_OFF_CNT}, 8'h10);
		cmds(1, 1);
		// Combined mode: key first refused, one flipped bit in each half fails
		rst(MODE_PW_KEY, 1'b1);
		cmds(0, 0);
		pres(ROLE_USER, KIND_KEY, upw, 64, key, 2'b01);
		pres(ROLE_USER, KIND_PW, upw, 64, key, 2'b10);
		chk("stage", {PW_STAGE_OK, USER_UNLOCKED}, 8'h02);
		pres(ROLE_USER, KIND_KEY, upw, 64, key ^ (512'h1 << 511), 2'b00);
		chk("stage dropped", PW_STAGE_OK, 8'h00);
		pres(ROLE_USER, KIND_PW, upw, 64, key, 2'b10);
		pres(ROLE_USER, KIND_KEY, upw, 64, key ^ 512'h1, 2'b00);
		chk("key fails", NV_USER_CNT, 8'h02);
		pres(ROLE_USER, KIND_PW, upw, 64, key, 2'b10);
		pres(ROLE_USER, KIND_KEY, upw, 64, key, 2'b10);
		chk("key unlock", {USER_UNLOCKED, NV_USER_CNT}, 8'h10);
		// Key mode, slow store: saturate without wipe, then wipe at power-up
		slow = 1;
		rst(MODE_KEY, 1'b0);
		pres(ROLE_USER, KIND_PW, upw, 64, key, 2'b01);
		for (int i = 0; i < 16; i++) pres(ROLE_USER, KIND_KEY, upw, 64, mkkey(), 2'b00);
		chk("saturated", {erase_seen, NV_USER_CNT}, 8'h0f);
		rst(MODE_KEY, 1'b0);
		waitrdy();
		chk("count kept", NV_USER_CNT, 8'h0f);
		rst(MODE_KEY, 1'b1);
		waitrdy();
		chk("power-up wipe", {erase_seen, NV_USER_CNT}, 8'h10);
		// Live wipe at exactly the limit drops an existing unlock
		erase_seen = 0;
		pres(ROLE_USER, KIND_KEY, upw, 64, key, 2'b10);
		for (int i = 0; i < 14; i++) pres(ROLE_USER, KIND_KEY, upw, 64, mkkey(), 2'b00);
		chk("below limit", {erase_seen, USER_UNLOCKED, NV_USER_CNT}, 8'h1e);
		pres(ROLE_USER, KIND_KEY, upw, 64, mkkey(), 2'b00);
		waitrdy();
		chk("wiped", {erase_seen, USER_UNLOCKED, NV_USER_CNT}, 8'h20);
		cmds(0, 0);
		chk("pending", 8'(q.size()), 8'h00);
		close_out();
	end
endmodule : auth_lockout_test

//--- auth_pkg.sv
// Shared constants and types for the authentication gate and failure lockout.
// Assumes one device clock; the secret store and persistent counter live outside.
package auth_pkg;

	// Consecutive failures that trigger the wipe
	localparam int PENALTY_LIMIT = 15;
	// Width of one persistent failure counter
	localparam int CNT_W = 4;
	// User password field, bytes and bits
	localparam int USER_PW_BYTES = 64;
	localparam int USER_PW_BITS = USER_PW_BYTES * 8;
	// Length field wide enough to show an over-long password
	localparam int PW_LEN_W = 7;
	// Officer configuration password field
	localparam int CFG_PW_BYTES = 32;
	localparam int CFG_PW_BITS = CFG_PW_BYTES * 8;
	// Each half of a wrapped media key
	localparam int KEY_HALF_BITS = 256;
	// Counter value after reset and after a success
	localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;

	// Controller states
	typedef enum logic [2:0] {S_LOAD, S_IDLE, S_CHECK, S_NVWR, S_ERASE} state_t;
	// User authentication mode
	typedef enum logic [1:0] {MODE_PW, MODE_KEY, MODE_PW_KEY} mode_t;
	// Role of a credential presentation
	typedef enum logic {ROLE_USER, ROLE_OFFICER} role_t;
	// Kind of a user credential
	typedef enum logic {KIND_PW, KIND_KEY} kind_t;
	// Host command classes seen by the gate
	typedef enum logic [1:0] {CMD_INFO, CMD_READ, CMD_WRITE, CMD_CONFIG} cmd_class_t;

endpackage : auth_pkg

//--- cred_compare.sv
// Combinational credential comparator.
// Assumes inputs are registered upstream; verdicts settle within one cycle.
`timescale 1ns/1ps
module cred_compare (
	cred_if.comp cif
);
	import auth_pkg::*;

	// Per-byte equality, bytes past the length count as equal
	logic [USER_PW_BYTES-1:0] byte_eq;
	// Length is legal only from one byte up to the full field
	logic len_ok;

	// One comparator per password byte
	genvar i;
	generate
		for (i = 0; i < USER_PW_BYTES; i++)
		begin : g_byte
			assign byte_eq[i] = (PW_LEN_W'(i) >= cif.pw_len) ||
				(cif.pw[8*i +: 8] == cif.ref_pw[8*i +: 8]);
		end
	endgenerate

	assign len_ok = (cif.pw_len != '0) && (cif.pw_len <= PW_LEN_W'(USER_PW_BYTES));
	// Length must match too, else a prefix would pass
	assign cif.pw_match = len_ok && (cif.pw_len == cif.ref_pw_len) && (&byte_eq);
	assign cif.key_match = (cif.cipher == cif.ref_cipher) && (cif.tweak == cif.ref_tweak);
	assign cif.cfg_match = (cif.pw[CFG_PW_BITS-1:0] == cif.ref_cfg);

endmodule : cred_compare

//--- cred_if.sv
// Carrier between the lockout controller and the credential comparator.
// Assumes the controller holds the presented values stable while it checks them.
`timescale 1ns/1ps
interface cred_if;
	import auth_pkg::*;
	// Presented credential
	logic [USER_PW_BITS-1:0] pw;
	logic [PW_LEN_W-1:0] pw_len;
	logic [KEY_HALF_BITS-1:0] cipher;
	logic [KEY_HALF_BITS-1:0] tweak;
	// Stored reference secrets
	logic [USER_PW_BITS-1:0] ref_pw;
	logic [PW_LEN_W-1:0] ref_pw_len;
	logic [CFG_PW_BITS-1:0] ref_cfg;
	logic [KEY_HALF_BITS-1:0] ref_cipher;
	logic [KEY_HALF_BITS-1:0] ref_tweak;
	// Verdicts
	logic pw_match;
	logic key_match;
	logic cfg_match;

	// Controller side
	modport ctrl (
		output pw, pw_len, cipher, tweak, ref_pw, ref_pw_len, ref_cfg, ref_cipher, ref_tweak,
		input pw_match, key_match, cfg_match
	);
	// Comparator side
	modport comp (
		input pw, pw_len, cipher, tweak, ref_pw, ref_pw_len, ref_cfg, ref_cipher, ref_tweak,
		output pw_match, key_match, cfg_match
	);
endinterface : cred_if

//--- nv_store_model.sv
// Persistent failure-count store and media-erase engine beside the gate.
// Assumes one request at a time; counts survive every reset of the gate.
`timescale 1ns/1ps
module nv_store_model
	import auth_pkg::*;
(
	input logic clk,
	input logic slow,
	input logic wr_en,
	input logic [CNT_W-1:0] wr_user,
	input logic [CNT_W-1:0] wr_off,
	input logic erase_req,
	output logic [CNT_W-1:0] user_cnt,
	output logic [CNT_W-1:0] off_cnt,
	output logic wr_ack,
	output logic erase_done
);
	int wait_r = 0; // Cycles spent on the current request

	// Blank store at power-up only
	initial
	begin
		user_cnt = CNT_RESET;
		off_cnt = CNT_RESET;
		wr_ack = 1'b0;
		erase_done = 1'b0;
	end

	// counts change only on an acknowledged write, never on reset
	// erase completes after a delay, slow mode stretches it
	always @(posedge clk)
	begin
		wr_ack <= 1'b0;
		erase_done <= 1'b0;
		if ((wr_en || erase_req) && !wr_ack && !erase_done)
		begin
			wait_r <= wait_r + 1;
			if (wait_r >= (slow ? 5 : 0))
			begin
				wait_r <= 0;
				if (erase_req)
					erase_done <= 1'b1;
				else
				begin
					wr_ack <= 1'b1;
					user_cnt <= wr_user;
					off_cnt <= wr_off;
				end
			end
		end
	end
endmodule : nv_store_model
